// ---- logic/pbsp_port.sv ----
// Notes on behaviour
// - Sleep input parks device, memory contents kept
// - Input data captured into register on edge
// - Read drives data of address sampled at start
// - Output enable low lets lines drive, high releases
// - Release lines on write data, after deselect, deselected
// - Parity lines act as data, gated per lane
// - Strap low linear order, high interleaved order
// - Clock qualify high freezes access state; synchronisers and sleep logic keep running
// - All synchronous inputs registered on rising edge
// - Read data leaves through output register only
// - Three selects plus load low start access
// - Write strobe at start picks read or write
// - Only enabled byte lanes get written
// - Writes self-timed, no host write pulse
// - Reads, writes, deselects pipelined at fixed depth
// - Advance steps two-bit counter from low bits
// - First, third selects low active; second high
// - Byte lane strobes low active, qualify write
`timescale 1ns/100ps
`include "pbsp_regs.svh"

module pbsp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronous address and control
  input wire pbsp_pkg::pbsp_addr_t addr,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic write_strobe_n,
  input wire pbsp_pkg::pbsp_lane_t byte_lane_write_n,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  // Asynchronous controls and strap
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  // Data lines
  input wire pbsp_pkg::pbsp_data_t data_in,
  output pbsp_pkg::pbsp_data_t data_out,
  output pbsp_pkg::pbsp_data_t data_oe_n,
  // Parity lines
  input wire pbsp_pkg::pbsp_lane_t lane_parity_lines_in,
  output pbsp_pkg::pbsp_lane_t lane_parity_lines_out,
  output pbsp_pkg::pbsp_lane_t lane_parity_lines_oe_n,
  // Status
  output logic sleep_active
);
  import pbsp_pkg::*;

  logic qual;
  logic selected;
  logic awake;
  logic [`PBSP_ASY_W-1:0] asy_raw;
  logic [`PBSP_ASY_W-1:0] sync1_reg;
  logic [`PBSP_ASY_W-1:0] sync2_reg;
  logic [`PBSP_ASY_W-1:0] sync3_reg;
  logic [`PBSP_ASY_W-1:0] filt_reg;
  logic sleep_filt;
  logic mode_filt;
  logic oe_n_filt;
  pbsp_power_e power_reg;
  pbsp_power_e power_next;
  logic sleep_active_reg;
  pbsp_op_e a_op_reg;
  pbsp_hi_t a_hi_reg;
  pbsp_lane_t a_bw_n_reg;
  pbsp_ofs_t a_ofs;
  pbsp_addr_t acc_addr;
  logic ctr_load;
  logic ctr_advance;
  pbsp_op_e b_op_reg;
  pbsp_addr_t b_addr_reg;
  pbsp_lane_t b_bw_n_reg;
  logic c_valid_reg;
  pbsp_addr_t c_addr_reg;
  pbsp_lane_t c_bw_n_reg;
  pbsp_word_t din_reg;
  pbsp_word_t pin_word;
  pbsp_word_t mem_word;
  pbsp_word_t fwd_word;
  logic b_hit;
  logic c_hit;
  logic array_we;
  pbsp_word_t rd_data_reg;
  logic drive_reg;
  logic drive_next;
  logic oe_n_next;
  pbsp_data_t data_oe_n_reg;
  pbsp_lane_t parity_oe_n_reg;

  // Clock qualify gates the access pipeline; synchronisers and sleep logic run every clock
  assign qual = ~clock_qualify_n;

  assign selected = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;

  // Asynchronous pins: three stages, accept once stages two and three agree
  assign asy_raw = {output_enable_n, burst_order_strap, sleep_request};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= `PBSP_ASY_RST;
      sync2_reg <= `PBSP_ASY_RST;
      sync3_reg <= `PBSP_ASY_RST;
    end else begin
      sync1_reg <= asy_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_reg <= `PBSP_ASY_RST;
    end else begin
      filt_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);
    end
  end

  assign sleep_filt = filt_reg[`PBSP_ASY_SLEEP];
  assign mode_filt = filt_reg[`PBSP_ASY_MODE];
  assign oe_n_filt = filt_reg[`PBSP_ASY_OE_N];

  // Sleep runs off the raw clock: two clocks to enter, two to leave
  always_comb begin
    power_next = power_reg;
    case (power_reg)
      PBSP_PWR_AWAKE: begin
        if (sleep_filt) begin
          power_next = PBSP_PWR_ENTER;
        end
      end
      PBSP_PWR_ENTER: begin
        power_next = PBSP_PWR_ASLEEP;
      end
      PBSP_PWR_ASLEEP: begin
        if (!sleep_filt) begin
          power_next = PBSP_PWR_WAKE;
        end
      end
      PBSP_PWR_WAKE: begin
        power_next = PBSP_PWR_AWAKE;
      end
      default: begin
        power_next = PBSP_PWR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_reg <= PBSP_PWR_AWAKE;
    end else begin
      power_reg <= power_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_active_reg <= 1'b0;
    end else begin
      sleep_active_reg <= (power_next != PBSP_PWR_AWAKE);
    end
  end

  assign awake = (power_reg == PBSP_PWR_AWAKE);

  // Burst counter loads low bits on a start, steps on advance
  assign ctr_load = qual & awake & ~advance_or_load & selected;
  assign ctr_advance = qual & awake & advance_or_load;

  pbsp_burst_ctr u_ctr (
    .clk(clk),
    .rst(rst),
    .load(ctr_load),
    .advance(ctr_advance),
    .interleaved(mode_filt),
    .base(addr[`PBSP_OFS_W-1:0]),
    .offset(a_ofs)
  );

  // Address stage: access type is fixed at the load and kept through the burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_op_reg <= PBSP_OP_IDLE;
    end else if (qual) begin
      if (!awake) begin
        a_op_reg <= PBSP_OP_IDLE;
      end else if (!advance_or_load) begin
        if (selected) begin
          a_op_reg <= write_strobe_n ? PBSP_OP_READ : PBSP_OP_WRITE;
        end else begin
          a_op_reg <= PBSP_OP_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_hi_reg <= '0;
    end else if (ctr_load) begin
      a_hi_reg <= addr[`PBSP_ADDR_W-1:`PBSP_OFS_W];
    end
  end

  // Lane strobes are taken every beat so a burst write can vary them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_bw_n_reg <= '1;
    end else if (qual) begin
      a_bw_n_reg <= byte_lane_write_n;
    end
  end

  assign acc_addr = {a_hi_reg, a_ofs};

  // Write pipe: one stage holds the write while its data phase runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_op_reg <= PBSP_OP_IDLE;
      b_addr_reg <= '0;
      b_bw_n_reg <= '1;
    end else if (qual) begin
      b_op_reg <= a_op_reg;
      b_addr_reg <= acc_addr;
      b_bw_n_reg <= a_bw_n_reg;
    end
  end

  // Data register catches the pins on the write's data edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_valid_reg <= 1'b0;
      c_addr_reg <= '0;
      c_bw_n_reg <= '1;
      din_reg <= '0;
    end else if (qual) begin
      c_valid_reg <= (b_op_reg == PBSP_OP_WRITE);
      c_addr_reg <= b_addr_reg;
      c_bw_n_reg <= b_bw_n_reg;
      din_reg <= pin_word;
    end
  end

  // Array commit is internal, one qualified edge after capture
  assign array_we = qual & c_valid_reg;

  pbsp_array u_array (
    .clk(clk),
    .we(array_we),
    .waddr(c_addr_reg),
    .wlane_n(c_bw_n_reg),
    .wdata(din_reg),
    .raddr(acc_addr),
    .rdata(mem_word)
  );

  assign b_hit = (b_op_reg == PBSP_OP_WRITE) && (b_addr_reg == acc_addr);
  assign c_hit = c_valid_reg && (c_addr_reg == acc_addr);

  // Per lane: pack parity with its byte, forward writes not yet in the array
  genvar gi;
  generate
    for (gi = 0; gi < `PBSP_LANES; gi++) begin : g_lane
      localparam int LO = gi * `PBSP_LANE_W;
      assign pin_word[LO +: `PBSP_LANE_W] =
        {lane_parity_lines_in[gi], data_in[gi*`PBSP_BYTE_W +: `PBSP_BYTE_W]};
      assign fwd_word[LO +: `PBSP_LANE_W] =
        (b_hit && !b_bw_n_reg[gi]) ? pin_word[LO +: `PBSP_LANE_W] :
        (c_hit && !c_bw_n_reg[gi]) ? din_reg[LO +: `PBSP_LANE_W] :
        mem_word[LO +: `PBSP_LANE_W];
      assign data_out[gi*`PBSP_BYTE_W +: `PBSP_BYTE_W] =
        rd_data_reg[LO +: `PBSP_BYTE_W];
      assign lane_parity_lines_out[gi] = rd_data_reg[LO + `PBSP_BYTE_W];
    end
  endgenerate

  // Output register: array data never reaches the pins directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (qual && a_op_reg == PBSP_OP_READ) begin
      rd_data_reg <= fwd_word;
    end
  end

  // Drive only a read's data slot; idle and write slots release the bus
  assign drive_next = qual ? (a_op_reg == PBSP_OP_READ) : drive_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_reg <= `PBSP_DRIVE_RST;
    end else begin
      drive_reg <= drive_next;
    end
  end

  // Output enable is synchronised, so it acts a few clocks late
  assign oe_n_next = ~(drive_next & ~oe_n_filt & awake);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_oe_n_reg <= '1;
      parity_oe_n_reg <= '1;
    end else begin
      data_oe_n_reg <= {`PBSP_DATA_W{oe_n_next}};
      parity_oe_n_reg <= {`PBSP_LANES{oe_n_next}};
    end
  end

  assign data_oe_n = data_oe_n_reg;
  assign lane_parity_lines_oe_n = parity_oe_n_reg;
  assign sleep_active = sleep_active_reg;
endmodule

// ---- logic/pbsp_regs.svh ----
`ifndef PBSP_REGS_SVH
`define PBSP_REGS_SVH

// Array geometry
`define PBSP_ADDR_W 17
`define PBSP_DEPTH 131072
`define PBSP_LANES 4
`define PBSP_BYTE_W 8
`define PBSP_LANE_W 9
`define PBSP_DATA_W 32
`define PBSP_WORD_W 36
`define PBSP_OFS_W 2
`define PBSP_HI_W 15

// Bit positions inside the asynchronous input group {oe_n, strap, sleep}
`define PBSP_ASY_SLEEP 0
`define PBSP_ASY_MODE 1
`define PBSP_ASY_OE_N 2
`define PBSP_ASY_W 3

// Reset values: awake, interleaved order, outputs released
`define PBSP_ASY_RST 3'h6
`define PBSP_OFS_RST 2'h0
`define PBSP_DRIVE_RST 1'b0

`endif

// ---- logic/pbsp_pkg.sv ----
package pbsp_pkg;
  `include "pbsp_regs.svh"

  typedef logic [`PBSP_ADDR_W-1:0] pbsp_addr_t;
  typedef logic [`PBSP_HI_W-1:0] pbsp_hi_t;
  typedef logic [`PBSP_OFS_W-1:0] pbsp_ofs_t;
  typedef logic [`PBSP_WORD_W-1:0] pbsp_word_t;
  typedef logic [`PBSP_DATA_W-1:0] pbsp_data_t;
  typedef logic [`PBSP_LANES-1:0] pbsp_lane_t;

  typedef enum logic [2:0] {
    PBSP_OP_IDLE = 3'h1,
    PBSP_OP_READ = 3'h2,
    PBSP_OP_WRITE = 3'h4
  } pbsp_op_e;

  typedef enum logic [3:0] {
    PBSP_PWR_AWAKE = 4'h1,
    PBSP_PWR_ENTER = 4'h2,
    PBSP_PWR_ASLEEP = 4'h4,
    PBSP_PWR_WAKE = 4'h8
  } pbsp_power_e;
endpackage

// ---- logic/pbsp_burst_ctr.sv ----
`timescale 1ns/100ps
`include "pbsp_regs.svh"

module pbsp_burst_ctr (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic advance,
  input wire logic interleaved,
  input wire pbsp_pkg::pbsp_ofs_t base,
  // Current burst offset
  output pbsp_pkg::pbsp_ofs_t offset
);
  import pbsp_pkg::*;

  pbsp_ofs_t base_reg;
  pbsp_ofs_t count_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_reg <= `PBSP_OFS_RST;
    end else if (load) begin
      base_reg <= base;
    end
  end

  // Counter wraps after four beats; advance ignores chip selects
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= `PBSP_OFS_RST;
    end else if (load) begin
      count_reg <= `PBSP_OFS_RST;
    end else if (advance) begin
      count_reg <= count_reg + 2'h1;
    end
  end

  // Strap picks xor walk or wrapping add
  assign offset = interleaved ? (base_reg ^ count_reg) : (base_reg + count_reg);
endmodule

// ---- logic/pbsp_array.sv ----
`timescale 1ns/100ps
`include "pbsp_regs.svh"

module pbsp_array (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire pbsp_pkg::pbsp_addr_t waddr,
  input wire pbsp_pkg::pbsp_lane_t wlane_n,
  input wire pbsp_pkg::pbsp_word_t wdata,
  // Read port
  input wire pbsp_pkg::pbsp_addr_t raddr,
  output pbsp_pkg::pbsp_word_t rdata
);
  import pbsp_pkg::*;

  // No reset on storage: contents survive sleep and reset alike
  genvar gi;
  generate
    for (gi = 0; gi < `PBSP_LANES; gi++) begin : g_lane
      logic [`PBSP_LANE_W-1:0] mem [`PBSP_DEPTH];
      always_ff @(posedge clk) begin
        if (we && !wlane_n[gi]) begin
          mem[waddr] <= wdata[gi*`PBSP_LANE_W +: `PBSP_LANE_W];
        end
      end
      assign rdata[gi*`PBSP_LANE_W +: `PBSP_LANE_W] = mem[raddr];
    end
  endgenerate
endmodule

// ---- dv/pbsp_port_asserts.sv ----
`timescale 1ns/100ps
module pbsp_port_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controls
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic write_strobe_n,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Outputs
  input wire pbsp_pkg::pbsp_data_t data_out,
  input wire pbsp_pkg::pbsp_data_t data_oe_n,
  input wire pbsp_pkg::pbsp_lane_t lane_parity_lines_oe_n,
  input wire logic sleep_active
);
  import pbsp_pkg::*;
  wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  wire ld = !clock_qualify_n && !advance_or_load;
  wire rd_go = ld && sel && write_strobe_n;
  wire wr_go = ld && sel && !write_strobe_n;
  wire ds_go = ld && !sel;
  // Filtered inputs need several quiet cycles before the port may be judged
  wire calm = !output_enable_n && !sleep_request && !sleep_active;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_oe_off: assert property ((output_enable_n && !clock_qualify_n) [*6] |-> &data_oe_n)
    else $error("outputs driven while output enable high");
  chk_hold_frozen: assert property (clock_qualify_n |=> $stable(data_out))
    else $error("read data moved on an ignored edge");
  chk_wr_release: assert property (wr_go ##1 !clock_qualify_n |=> &data_oe_n)
    else $error("outputs driven in write data phase");
  chk_desel_release: assert property (ds_go ##1 !clock_qualify_n |=> &data_oe_n)
    else $error("outputs driven after deselect");
  chk_rd_latency: assert property (calm [*6] ##0 rd_go ##1 !clock_qualify_n |=> !data_oe_n[0])
    else $error("read data not driven one clock after start");
  chk_lanes_same: assert property (
    data_oe_n == {32{data_oe_n[0]}} && lane_parity_lines_oe_n == {4{data_oe_n[0]}})
    else $error("parity enables differ from data enables");
  chk_sleep_enter: assert property (sleep_request [*8] |-> sleep_active)
    else $error("sleep not entered");
  chk_sleep_quiet: assert property ((sleep_active && !clock_qualify_n) [*4] |-> &data_oe_n)
    else $error("outputs driven while asleep");
  cov_read: cover property (rd_go);
  cov_write: cover property (wr_go);
  cov_sleep: cover property (sleep_active);
  cov_burst_wr: cover property (wr_go ##1 (!clock_qualify_n && advance_or_load));
endmodule

bind pbsp_port pbsp_port_asserts u_chk (
  .clk, .rst, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
  .write_strobe_n, .advance_or_load, .clock_qualify_n, .output_enable_n, .sleep_request,
  .data_out, .data_oe_n, .lane_parity_lines_oe_n, .sleep_active
);

// ---- dv/pbsp_host_model.sv ----
`timescale 1ns/100ps
module pbsp_host_model (
  // Clock
  input wire logic clk,
  // Write data request
  input wire logic drive,
  input wire pbsp_pkg::pbsp_word_t word,
  // Device pin inputs
  output pbsp_pkg::pbsp_data_t data_in,
  output pbsp_pkg::pbsp_lane_t lane_parity_lines_in
);
  import pbsp_pkg::*;
  pbsp_word_t idle_reg = '0;
  // Released lines toggle so a stale value never passes for written data
  // Idle pattern moves on the falling edge, like every other stimulus
  always @(negedge clk) begin
    idle_reg <= ~idle_reg;
  end
  assign {lane_parity_lines_in, data_in} = drive ? word : idle_reg;
endmodule

// ---- dv/test_pbsp_port.sv ----
`timescale 1ns/100ps
module test_pbsp_port;
  import pbsp_pkg::*;
  logic clk = 0, rst = 1, drive = 0, sleep_active;
  logic chip_select_first_n = 1, chip_select_second = 0, chip_select_third_n = 1;
  logic write_strobe_n = 1, advance_or_load = 0, clock_qualify_n = 0;
  logic output_enable_n = 0, burst_order_strap = 1;
  logic sleep_request = 0;
  pbsp_addr_t addr = '0;
  pbsp_lane_t byte_lane_write_n = '1, lane_parity_lines_in;
  pbsp_lane_t lane_parity_lines_out, lane_parity_lines_oe_n;
  pbsp_word_t word = '0;
  pbsp_data_t data_in, data_out, data_oe_n;
  int miscompares = 0, comparisons = 0;

  pbsp_port u_dut (.clk, .rst, .addr, .chip_select_first_n, .chip_select_second,
    .chip_select_third_n, .write_strobe_n, .byte_lane_write_n, .advance_or_load,
    .clock_qualify_n, .output_enable_n, .sleep_request, .burst_order_strap, .data_in,
    .data_out, .data_oe_n, .lane_parity_lines_in, .lane_parity_lines_out,
    .lane_parity_lines_oe_n, .sleep_active);
  pbsp_host_model u_host (.clk, .drive, .word, .data_in, .lane_parity_lines_in);

  initial begin
    forever #4 clk = ~clk;
  end

  function automatic pbsp_word_t pat(input pbsp_addr_t a);
    return {a[3:0], ~a[15:0], a[15:0]};
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input pbsp_word_t exp, input pbsp_word_t got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op(input logic s, input logic wn, input logic adv, input pbsp_addr_t a,
      input pbsp_lane_t bw);
    @(negedge clk);
    drive = 0;
    chip_select_first_n = !s;
    chip_select_second = s;
    chip_select_third_n = !s;
    write_strobe_n = wn;
    advance_or_load = adv;
    addr = a;
    byte_lane_write_n = bw;
  endtask

  task automatic wr(input pbsp_addr_t a, input pbsp_word_t w, input pbsp_lane_t bw);
    op(1, 0, 0, a, bw);
    op(0, 1, 0, a, '1);
    @(negedge clk);
    drive = 1;
    word = w;
  endtask

  task automatic rd(input pbsp_addr_t a, input pbsp_word_t exp);
    op(1, 1, 0, a, '1);
    op(0, 1, 0, a, '1);
    @(negedge clk);
    check("read data", exp, {lane_parity_lines_out, data_out});
    check("read drive", '0, {lane_parity_lines_oe_n, data_oe_n});
  endtask

  task automatic sc_burst(input logic s, input pbsp_ofs_t b);
    pbsp_ofs_t k;
    pbsp_addr_t e;
    burst_order_strap = s;
    repeat (6) @(negedge clk);
    op(1, 1, 0, {15'h4, b}, '1);
    for (int n = 1; n < 6; n++) begin
      op(0, 1, n < 4, '0, '1);
      k = pbsp_ofs_t'(n - 2);
      e = {15'h4, s ? (b ^ k) : pbsp_ofs_t'(b + k)};
      if (n >= 2) check("burst beat", pat(e), {lane_parity_lines_out, data_out});
    end
  endtask

  task automatic sc_partial();
    pbsp_word_t e;
    e = pat({15'h4, 2'h3});
    for (int i = 0; i < 4; i += 2) begin
      e[8*i +: 8] = 8'hc3;
      e[32 + i] = 1'b1;
    end
    wr({15'h4, 2'h3}, {4'hf, {4{8'hc3}}}, 4'ha);
    rd({15'h4, 2'h3}, e);
  endtask

  // Four-beat write burst in interleaved order, data two edges behind each address
  task automatic sc_burst_wr();
    op(1, 0, 0, {15'h5, 2'h1}, '0);
    op(0, 1, 1, '0, '0);
    for (int n = 2; n < 6; n++) begin
      @(negedge clk);
      advance_or_load = (n < 4);
      drive = 1;
      word = pat({15'h5, 2'h1 ^ pbsp_ofs_t'(n - 2)});
    end
    for (int i = 0; i < 4; i++) rd({15'h5, 2'(i)}, pat({15'h5, 2'(i)}));
  endtask

  task automatic sc_freeze();
    op(1, 1, 0, {15'h4, 2'h1}, '1);
    op(0, 1, 0, '0, '1);
    clock_qualify_n = 1;
    repeat (3) @(negedge clk);
    check("frozen drive", '1, {lane_parity_lines_oe_n, data_oe_n});
    clock_qualify_n = 0;
    @(negedge clk);
    check("thawed data", pat({15'h4, 2'h1}), {lane_parity_lines_out, data_out});
  endtask

  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (sleep_active !== lvl && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("sleep state", 36'(lvl), 36'(sleep_active));
    if (n == 20 && sleep_active !== lvl) print_verdict();
  endtask

  task automatic sc_sleep();
    sleep_request = 1;
    wait_sleep(1);
    op(1, 1, 0, {15'h4, 2'h0}, '1);
    op(0, 1, 0, '0, '1);
    @(negedge clk);
    check("sleep drive", '1, {lane_parity_lines_oe_n, data_oe_n});
    sleep_request = 0;
    wait_sleep(0);
    repeat (4) @(negedge clk);
    rd({15'h4, 2'h0}, pat({15'h4, 2'h0}));
  endtask

  task automatic sc_oe_off();
    output_enable_n = 1;
    repeat (6) @(negedge clk);
    op(1, 1, 0, {15'h4, 2'h2}, '1);
    op(0, 1, 0, '0, '1);
    @(negedge clk);
    check("disabled drive", '1, {lane_parity_lines_oe_n, data_oe_n});
    output_enable_n = 0;
    repeat (6) @(negedge clk);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 4; i++) wr({15'h4, 2'(i)}, pat({15'h4, 2'(i)}), '0);
    sc_burst(0, 2'h1);
    sc_burst(1, 2'h2);
    sc_burst_wr();
    sc_partial();
    sc_freeze();
    sc_oe_off();
    sc_sleep();
    print_verdict();
  end
endmodule
